// [design/mic_clk_div.sv]
// Purpose: CPU clock divider, divide by 2 or by 32
// Assumes: core_clk_i is the oscillator reference
// Notes:   Ratio change is taken at the end of the current period, no glitch
`timescale 1ns/100ps
module mic_clk_div
	import mic_pkg::*;
(
	// Clock and reset
	input  wire logic core_clk_i,
	input  wire logic reset_n_i,
	// Control
	input  wire logic slow_i,
	// Divided clock
	output logic      cpu_clk_o,
	output logic      cpu_tick_o
);

	logic [5:0] cnt_ff;
	logic [5:0] div_ff;
	logic       clk_ff;
	wire        wrap;

	assign wrap       = (cnt_ff == div_ff - 6'h01);
	assign cpu_clk_o  = clk_ff;
	assign cpu_tick_o = wrap;

	always_ff @(posedge core_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			cnt_ff <= 6'h00;
			div_ff <= DIV_NORMAL;
			clk_ff <= 1'b0;
		end
		else
		begin
			cnt_ff <= wrap ? 6'h00 : cnt_ff + 6'h01;
			div_ff <= wrap ? (slow_i ? DIV_SLOW : DIV_NORMAL) : div_ff;
			clk_ff <= (cnt_ff < (div_ff >> 1));
		end
	end

endmodule

// [design/mic_ext_grp.sv]
// Purpose: One external interrupt group: pin AND, sensitivity, request latch
// Assumes: Pins are asynchronous; polarity and enables come from core logic
// Notes:   Level request follows the combined input and is never latched
`timescale 1ns/100ps
module mic_ext_grp
	import mic_pkg::*;
#(
	parameter int W = 8
)
(
	// Clock and reset
	input  wire logic         core_clk_i,
	input  wire logic         reset_n_i,
	// Pins and configuration
	input  wire logic [W-1:0] pins_i,
	input  wire logic [W-1:0] irq_en_i,
	input  wire logic [1:0]   polarity_i,
	// Service
	input  wire logic         ack_i,
	output logic              req_o
);

	logic [W-1:0] sync1_ff;
	logic [W-1:0] sync2_ff;
	logic         comb_ff;
	logic [1:0]   pol_ff;
	logic         latch_ff;
	logic         nxt_latch;
	wire          combined;
	wire          fall;
	wire          rise;
	wire          edge_hit;
	wire          pol_chg;

	// Disabled pins read as high so they never block the group
	assign combined = &(sync2_ff | ~irq_en_i);
	assign fall     = comb_ff & ~combined;
	assign rise     = ~comb_ff & combined;
	assign edge_hit = (polarity_i == POL_RISE) ? rise :
	                  (polarity_i == POL_BOTH) ? (rise | fall) : fall;
	assign pol_chg  = (polarity_i != pol_ff);
	// Edge latch cleared by service entry or by a polarity change
	assign nxt_latch = pol_chg ? 1'b0 : (edge_hit | (latch_ff & ~ack_i));
	// Low level keeps the request up and re-arms it after return
	assign req_o = latch_ff | ((pol_ff == POL_FALL_LOW) & ~comb_ff);

	always_ff @(posedge core_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			sync1_ff <= '1;
			sync2_ff <= '1;
			comb_ff  <= 1'b1;
			pol_ff   <= POL_FALL_LOW;
			latch_ff <= 1'b0;
		end
		else
		begin
			sync1_ff <= pins_i;
			sync2_ff <= sync1_ff;
			comb_ff  <= combined;
			pol_ff   <= polarity_i;
			latch_ff <= nxt_latch;
		end
	end

endmodule

// [design/mic_irq_ctrl.sv]
// Purpose: Interrupt sequencing, stacking, vectoring, wait/halt and slow clock
// Assumes: Stack read data is valid in the cycle the read strobe is high
// Notes:   Core stalls while core_stall_o is high; one instruction per instr_end_i
//
// Behaviour
// - Maskable requests serviced only with mask flag clear, otherwise held.
// - Requests accepted only at the end of the current instruction.
// - Entry pushes program counter, index, accumulator and condition codes.
// - Five bytes stacked, low PC byte first, pointer decremented per push.
// - Mask flag set after stacking on entry.
// - Vectors: reset FFFE, trap FFFC, group A FFFA.
// - Group B joins port B and port C pins 0-5, vector FFF8.
// - Fixed priority: reset, trap, A, B, serial, timer A, timer B.
// - Return pops context, restores mask flag from the stacked condition codes, resumes program.
// - Trap entered regardless of mask flag.
// - Any source wakes the core from Wait.
// - Only reset and external groups wake from Halt.
// - Group sensitivity taken from polarity bits.
// - Polarity 00 fall+low, 10 fall, 01 rise, 11 both edges.
// - Changing a group's polarity discards its pending request.
// - Edge request latched, cleared on entering its service routine.
// - Enabled pins of a group ANDed before detection.
// - One enabled pin held low blocks the group's request.
// - Peripheral flag interrupts only with enable set and mask clear.
// - Clear sequence resets the latch, losing a not-yet-enabled request.
// - Wait and Halt by instruction, Slow by select bit.
// - Wait stops core, peripherals run, mask flag cleared.
// - Wait lasts until reset or interrupt, then branches to its routine.
// - Slow mode clocks core and peripherals from the reduced clock.
// - CPU clock is oscillator over 2, or over 32 when slow.
`timescale 1ns/100ps
module mic_irq_ctrl
	import mic_pkg::*;
(
	// Clock and reset
	input  wire logic        core_clk_i,
	input  wire logic        reset_n_i,
	// Core instruction events
	input  wire logic        instr_end_i,
	input  wire logic        trap_exec_i,
	input  wire logic        interrupt_return_instruction_exec_i,
	input  wire logic        wfi_exec_i,
	input  wire logic        halt_exec_i,
	input  wire logic        set_mask_i,
	input  wire logic        clr_mask_i,
	// Core context
	input  wire logic [15:0] program_counter_i,
	input  wire logic [7:0]  index_reg_i,
	input  wire logic [7:0]  accum_i,
	input  wire logic [7:0]  condition_code_register_i,
	input  wire logic [15:0] stack_ptr_i,
	// Stack memory
	input  wire logic [7:0]  stack_rdata_i,
	output logic             stack_wr_o,
	output logic             stack_rd_o,
	output logic [15:0]      stack_addr_o,
	output logic [7:0]       stack_wdata_o,
	// Core control
	output logic             core_stall_o,
	output logic             sp_load_o,
	output logic [15:0]      sp_value_o,
	output logic             vector_load_o,
	output logic [15:0]      vector_addr_o,
	output logic             restore_valid_o,
	output logic [15:0]      restored_pc_o,
	output logic [7:0]       restored_x_o,
	output logic [7:0]       restored_a_o,
	output logic [7:0]       restored_cc_o,
	output logic             mask_flag_o,
	// Power modes
	output logic             core_stop_o,
	output logic             osc_stop_o,
	input  wire logic        slow_clock_select_i,
	output logic             cpu_clk_o,
	output logic             cpu_tick_o,
	// External interrupt pins
	input  wire logic [7:0]  port_a_pins_i,
	input  wire logic [7:0]  port_a_irq_en_i,
	input  wire logic [7:0]  port_b_pins_i,
	input  wire logic [7:0]  port_b_irq_en_i,
	input  wire logic [5:0]  port_c_low_pins_i,
	input  wire logic [5:0]  port_c_irq_en_i,
	input  wire logic [1:0]  group_a_polarity_bits_i,
	input  wire logic [1:0]  group_b_polarity_bits_i,
	// Peripheral requests
	input  wire logic [2:0]  periph_flag_set_i,
	input  wire logic [2:0]  periph_clr_i,
	input  wire logic [2:0]  periph_en_i,
	output logic [2:0]       periph_pending_o
);

	////////////////////////////////////////////////////////////////////////
	// Declarations

	mic_state_t  state_ff;
	mic_state_t  nxt_state;
	logic        mask_ff;
	logic        trap_ff;
	logic [2:0]  pend_ff;
	logic [2:0]  src_ff;
	logic [2:0]  cnt_ff;
	logic [15:0] sp_ff;
	logic [7:0]  ctx_ff [5];
	logic [7:0]  pop_ff [4];
	logic        ret_ff;
	logic [7:0]  pcl_ff;
	wire         grp_a_req;
	wire         grp_b_req;
	wire         ack_a;
	wire         ack_b;
	wire  [2:0]  per_req;
	wire  [6:0]  mask_req;
	wire  [6:0]  all_req;
	wire  [2:0]  win_src;
	wire         accept;
	wire         wake_wait;
	wire         wake_halt;
	wire  [7:0]  cc_push;

	function automatic logic [2:0] pick(input logic [6:0] req);
		logic [2:0] idx;
		idx = SRC_TIM_B;
		for (int i = 6; i >= 0; i--)
		begin
			if (req[i])
			begin
				idx = 3'(i);
			end
		end
		return idx;
	endfunction

	function automatic logic [15:0] vec_of(input logic [2:0] src);
		logic [15:0] v;
		case (src)
			SRC_RESET: v = VEC_RESET;
			SRC_TRAP:  v = VEC_TRAP;
			SRC_GRP_A: v = VEC_GRP_A;
			SRC_GRP_B: v = VEC_GRP_B;
			SRC_SPI:   v = VEC_SPI;
			SRC_TIM_A: v = VEC_TIM_A;
			default:   v = VEC_TIM_B;
		endcase
		return v;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Sources

	mic_ext_grp #(.W(8)) u_grp_a (
		.core_clk_i (core_clk_i),
		.reset_n_i  (reset_n_i),
		.pins_i     (port_a_pins_i),
		.irq_en_i   (port_a_irq_en_i),
		.polarity_i (group_a_polarity_bits_i),
		.ack_i      (ack_a),
		.req_o      (grp_a_req)
	);

	// Port B and port C low pins share one detector
	mic_ext_grp #(.W(14)) u_grp_b (
		.core_clk_i (core_clk_i),
		.reset_n_i  (reset_n_i),
		.pins_i     ({port_c_low_pins_i, port_b_pins_i}),
		.irq_en_i   ({port_c_irq_en_i, port_b_irq_en_i}),
		.polarity_i (group_b_polarity_bits_i),
		.ack_i      (ack_b),
		.req_o      (grp_b_req)
	);

	mic_clk_div u_div (
		.core_clk_i (core_clk_i),
		.reset_n_i  (reset_n_i),
		.slow_i     (slow_clock_select_i),
		.cpu_clk_o  (cpu_clk_o),
		.cpu_tick_o (cpu_tick_o)
	);

	assign per_req  = pend_ff & periph_en_i;
	assign all_req  = {per_req[PER_TIM_B], per_req[PER_TIM_A], per_req[PER_SPI],
	                   grp_b_req, grp_a_req, trap_ff, 1'b0};
	// Trap bypasses the mask flag, the rest wait for it to clear
	assign mask_req = {all_req[6:2] & {5{~mask_ff}}, trap_ff, 1'b0};
	assign win_src  = pick(mask_req);
	assign accept   = (state_ff == ST_RUN) & instr_end_i & (|mask_req);
	assign wake_wait = |all_req[6:2];
	assign wake_halt = grp_a_req | grp_b_req;
	assign ack_a    = (state_ff == ST_VECTOR) & (src_ff == SRC_GRP_A);
	assign ack_b    = (state_ff == ST_VECTOR) & (src_ff == SRC_GRP_B);
	assign cc_push  = {condition_code_register_i[7:CC_MASK_BIT+1], mask_ff,
	                   condition_code_register_i[CC_MASK_BIT-1:0]};

	////////////////////////////////////////////////////////////////////////
	// Sequencer

	always_comb
	begin
		nxt_state = state_ff;
		case (state_ff)
			ST_RESET_VEC: nxt_state = ST_RUN;
			ST_RUN:
			begin
				if (accept)
					nxt_state = ST_PUSH;
				else if (interrupt_return_instruction_exec_i)
					nxt_state = ST_POP;
				else if (wfi_exec_i)
					nxt_state = ST_WAIT;
				else if (halt_exec_i)
					nxt_state = ST_HALT;
			end
			ST_PUSH:   nxt_state = (cnt_ff == CTX_BYTES - 3'h1) ? ST_VECTOR : ST_PUSH;
			ST_VECTOR: nxt_state = ST_RUN;
			ST_POP:    nxt_state = (cnt_ff == CTX_BYTES - 3'h1) ? ST_RUN : ST_POP;
			ST_WAIT:   nxt_state = wake_wait ? ST_PUSH : ST_WAIT;
			ST_HALT:   nxt_state = wake_halt ? ST_PUSH : ST_HALT;
			default:   nxt_state = ST_RUN;
		endcase
	end

	always_ff @(posedge core_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			state_ff <= ST_RESET_VEC;
			cnt_ff   <= 3'h0;
		end
		else
		begin
			state_ff <= nxt_state;
			cnt_ff   <= (nxt_state == state_ff) && (state_ff inside {ST_PUSH, ST_POP}) ? cnt_ff + 3'h1 : 3'h0;
		end
	end

	// Source and context are frozen at acceptance so late changes cannot leak in
	always_ff @(posedge core_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			src_ff <= SRC_RESET;
			sp_ff  <= SP_RESET;
			for (int i = 0; i < 5; i++)
				ctx_ff[i] <= 8'h00;
		end
		else if (accept || (state_ff == ST_WAIT && wake_wait) || (state_ff == ST_HALT && wake_halt))
		begin
			src_ff    <= pick(all_req);
			sp_ff     <= stack_ptr_i;
			ctx_ff[0] <= program_counter_i[7:0];
			ctx_ff[1] <= program_counter_i[15:8];
			ctx_ff[2] <= index_reg_i;
			ctx_ff[3] <= accum_i;
			ctx_ff[4] <= cc_push;
		end
		else if (state_ff == ST_RUN && interrupt_return_instruction_exec_i)
			sp_ff <= stack_ptr_i + 16'h0001;
		else if (state_ff inside {ST_PUSH, ST_POP})
			sp_ff <= (state_ff == ST_PUSH) ? sp_ff - 16'h0001 : sp_ff + 16'h0001;
	end

	// Pop order is condition codes, accumulator, index, PC high, PC low
	always_ff @(posedge core_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			for (int i = 0; i < 4; i++)
				pop_ff[i] <= 8'h00;
			ret_ff <= 1'b0;
		end
		else
		begin
			if (stack_rd_o && cnt_ff != CTX_BYTES - 3'h1)
				pop_ff[cnt_ff[1:0]] <= stack_rdata_i;
			ret_ff <= (state_ff == ST_POP) && (cnt_ff == CTX_BYTES - 3'h1);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Mask flag, trap and peripheral latches

	always_ff @(posedge core_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			mask_ff <= 1'b1;
			trap_ff <= 1'b0;
			pend_ff <= 3'h0;
		end
		else
		begin
			if (state_ff == ST_VECTOR || state_ff == ST_RESET_VEC)
				mask_ff <= 1'b1;
			else if (state_ff == ST_POP && cnt_ff == CTX_BYTES - 3'h1)
				mask_ff <= pop_ff[0][CC_MASK_BIT];
			else if (state_ff == ST_RUN && (wfi_exec_i || halt_exec_i) && !accept)
				mask_ff <= 1'b0;
			else if (clr_mask_i)
				mask_ff <= 1'b0;
			else if (set_mask_i)
				mask_ff <= 1'b1;
			trap_ff <= trap_exec_i | (trap_ff & ~(state_ff == ST_VECTOR && src_ff == SRC_TRAP));
			// New flag wins over a clear in the same cycle
			pend_ff <= periph_flag_set_i | (pend_ff & ~periph_clr_i);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs

	assign core_stall_o    = (state_ff != ST_RUN);
	assign core_stop_o     = (state_ff == ST_WAIT) | (state_ff == ST_HALT);
	assign osc_stop_o      = (state_ff == ST_HALT);
	assign stack_wr_o      = (state_ff == ST_PUSH);
	assign stack_rd_o      = (state_ff == ST_POP);
	assign stack_addr_o    = sp_ff;
	assign stack_wdata_o   = ctx_ff[cnt_ff];
	assign sp_load_o       = (state_ff == ST_VECTOR) | ret_ff;
	assign sp_value_o      = (state_ff == ST_VECTOR) ? sp_ff : sp_ff - 16'h0001;
	assign vector_load_o   = (state_ff == ST_VECTOR) | (state_ff == ST_RESET_VEC);
	assign vector_addr_o   = (state_ff == ST_RESET_VEC) ? VEC_RESET : vec_of(src_ff);
	assign restore_valid_o = ret_ff;
	assign restored_cc_o   = pop_ff[0];
	assign restored_a_o    = pop_ff[1];
	assign restored_x_o    = pop_ff[2];
	assign restored_pc_o   = {pop_ff[3], pcl_ff};
	assign mask_flag_o     = mask_ff;
	assign periph_pending_o = pend_ff;

	// Last popped byte is the low PC byte
	always_ff @(posedge core_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			pcl_ff <= 8'h00;
		else if (stack_rd_o && cnt_ff == CTX_BYTES - 3'h1)
			pcl_ff <= stack_rdata_i;
	end

	////////////////////////////////////////////////////////////////////////
	// Checks

	property p_mask_gate;
		@(posedge core_clk_i) disable iff (!reset_n_i)
		accept && win_src != SRC_TRAP |-> !mask_ff;
	endproperty
	a_mask_gate: assert property (p_mask_gate) else $error("maskable accepted while masked");

	property p_boundary;
		@(posedge core_clk_i) disable iff (!reset_n_i)
		$rose(state_ff == ST_PUSH) && $past(state_ff) == ST_RUN |-> $past(instr_end_i);
	endproperty
	a_boundary: assert property (p_boundary) else $error("entry not on instruction end");

	property p_push5;
		@(posedge core_clk_i) disable iff (!reset_n_i)
		$rose(stack_wr_o) |-> stack_wr_o[*5] ##1 vector_load_o;
	endproperty
	a_push5: assert property (p_push5) else $error("context push not five bytes");

	property p_mask_set;
		@(posedge core_clk_i) disable iff (!reset_n_i)
		(state_ff == ST_VECTOR) |=> mask_ff;
	endproperty
	a_mask_set: assert property (p_mask_set) else $error("mask flag not set on entry");

	property p_vec_a;
		@(posedge core_clk_i) disable iff (!reset_n_i)
		(state_ff == ST_VECTOR) && src_ff == SRC_GRP_A |-> vector_addr_o == VEC_GRP_A ##1 !u_grp_a.latch_ff;
	endproperty
	a_vec_a: assert property (p_vec_a) else $error("group A vector or latch clear wrong");

	property p_trap;
		@(posedge core_clk_i) disable iff (!reset_n_i)
		(state_ff == ST_RUN) && trap_ff && instr_end_i |=> state_ff == ST_PUSH ##5 vector_addr_o == VEC_TRAP;
	endproperty
	a_trap: assert property (p_trap) else $error("trap not entered under mask");

	property p_wait;
		@(posedge core_clk_i) disable iff (!reset_n_i)
		(state_ff == ST_RUN) && wfi_exec_i && !accept && !interrupt_return_instruction_exec_i |=> state_ff == ST_WAIT && !mask_ff;
	endproperty
	a_wait: assert property (p_wait) else $error("wait entry wrong");

	property p_halt;
		@(posedge core_clk_i) disable iff (!reset_n_i)
		(state_ff == ST_HALT) && !grp_a_req && !grp_b_req |=> state_ff == ST_HALT;
	endproperty
	a_halt: assert property (p_halt) else $error("halt left without external request");

	property p_wake;
		@(posedge core_clk_i) disable iff (!reset_n_i)
		(state_ff == ST_WAIT) && per_req != 3'h0 |=> state_ff == ST_PUSH;
	endproperty
	a_wake: assert property (p_wake) else $error("peripheral did not wake wait");

endmodule

// [design/mic_pkg.sv]
// Purpose: Shared constants and types for the interrupt and wait control block
// Assumes: Core clock stands in for the oscillator; one source index per vector
// Notes:   Vector addresses are the low address of each two-byte vector pair
package mic_pkg;

	// Vector addresses
	localparam logic [15:0] VEC_RESET = 16'hfffe;
	localparam logic [15:0] VEC_TRAP  = 16'hfffc;
	localparam logic [15:0] VEC_GRP_A = 16'hfffa;
	localparam logic [15:0] VEC_GRP_B = 16'hfff8;
	localparam logic [15:0] VEC_SPI   = 16'hfff4;
	localparam logic [15:0] VEC_TIM_A = 16'hfff2;
	localparam logic [15:0] VEC_TIM_B = 16'hffee;

	// Source indices, lower index wins
	localparam logic [2:0] SRC_RESET = 3'h0;
	localparam logic [2:0] SRC_TRAP  = 3'h1;
	localparam logic [2:0] SRC_GRP_A = 3'h2;
	localparam logic [2:0] SRC_GRP_B = 3'h3;
	localparam logic [2:0] SRC_SPI   = 3'h4;
	localparam logic [2:0] SRC_TIM_A = 3'h5;
	localparam logic [2:0] SRC_TIM_B = 3'h6;

	// Peripheral request slots
	localparam int          NUM_PERIPH = 3;
	localparam int          PER_SPI    = 0;
	localparam int          PER_TIM_A  = 1;
	localparam int          PER_TIM_B  = 2;

	// External group sensitivity codes
	localparam logic [1:0] POL_FALL_LOW = 2'h0;
	localparam logic [1:0] POL_FALL     = 2'h2;
	localparam logic [1:0] POL_RISE     = 2'h1;
	localparam logic [1:0] POL_BOTH     = 2'h3;

	// Stack context
	localparam logic [2:0] CTX_BYTES   = 3'h5;
	localparam int         CC_MASK_BIT = 3;
	localparam logic [7:0] CC_RESET    = 8'h08;
	localparam logic [15:0] SP_RESET   = 16'h017f;

	// Clock divider ratios
	localparam logic [5:0] DIV_NORMAL = 6'h02;
	localparam logic [5:0] DIV_SLOW   = 6'h20;

	typedef enum logic [2:0] {
		ST_RESET_VEC,
		ST_RUN,
		ST_PUSH,
		ST_VECTOR,
		ST_POP,
		ST_WAIT,
		ST_HALT
	} mic_state_t;

endpackage

// [tb/mic_stack_mem.sv]
// Purpose: Stack memory model standing on the core side of the block
// Assumes: Read data is returned in the same cycle as the read strobe
// Notes:   Outside a read the data line shows the inverse of the last value read
`timescale 1ns/100ps
module mic_stack_mem
(
	// Clock
	input  wire logic        clk_i,
	// Stack port
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	input  wire logic [15:0] addr_i,
	input  wire logic [7:0]  wdata_i,
	output logic [7:0]       rdata_o
);
	logic [7:0] m [0:511];
	logic [7:0] last_ff = 8'h00;

	// A released data line must not keep looking valid
	assign rdata_o = rd_i ? m[addr_i[8:0]] : ~last_ff;

	always_ff @(posedge clk_i)
	begin
		if (wr_i)
			m[addr_i[8:0]] <= wdata_i;
		if (rd_i)
			last_ff <= m[addr_i[8:0]];
	end
endmodule

// [tb/test_mcu_interrupt_and_wait_control.sv]
// Purpose: Self-checking bench for the interrupt and wait control block
// Assumes: Inputs change at the falling edge; one instruction per end pulse
// Notes:   Core context is held constant, so stacked frames differ only in the stacked mask bit
`timescale 1ns/100ps
module test_mcu_interrupt_and_wait_control
	import mic_pkg::*;
();
	logic        core_clk_i = 1'b0, reset_n_i = 1'b0, instr_end_i = 1'b0, trap_exec_i = 1'b0;
	logic        interrupt_return_instruction_exec_i = 1'b0, wfi_exec_i = 1'b0, halt_exec_i = 1'b0, set_mask_i = 1'b0;
	logic        clr_mask_i = 1'b0, slow_clock_select_i = 1'b0;
	logic [15:0] program_counter_i = 16'h1234, stack_ptr_i = SP_RESET;
	logic [7:0]  index_reg_i = 8'h56, accum_i = 8'h78, condition_code_register_i = 8'ha1, stack_rdata_i;
	logic [7:0]  port_a_pins_i = 8'hff, port_a_irq_en_i = 8'h03, port_b_pins_i = 8'hff, port_b_irq_en_i = 8'h00;
	logic [5:0]  port_c_low_pins_i = 6'h3f, port_c_irq_en_i = 6'h01;
	logic [1:0]  group_a_polarity_bits_i = POL_RISE, group_b_polarity_bits_i = POL_FALL_LOW;
	logic [2:0]  periph_flag_set_i = 3'h0, periph_clr_i = 3'h0, periph_en_i = 3'h0, periph_pending_o;
	logic        stack_wr_o, stack_rd_o, core_stall_o, sp_load_o, vector_load_o, restore_valid_o;
	logic        mask_flag_o, core_stop_o, osc_stop_o, cpu_clk_o, cpu_tick_o;
	logic [15:0] stack_addr_o, sp_value_o, vector_addr_o, restored_pc_o;
	logic [7:0]  stack_wdata_o, restored_x_o, restored_a_o, restored_cc_o;
	logic [7:0]  exp_cc = 8'ha1;
	int          num_errors = 0, n_tests = 0;

	always #2 core_clk_i = ~core_clk_i;

	mic_irq_ctrl uut (.core_clk_i, .reset_n_i, .instr_end_i, .trap_exec_i, .interrupt_return_instruction_exec_i, .wfi_exec_i,
		.halt_exec_i, .set_mask_i, .clr_mask_i, .program_counter_i, .index_reg_i, .accum_i,
		.condition_code_register_i, .stack_ptr_i, .stack_rdata_i, .stack_wr_o, .stack_rd_o, .stack_addr_o,
		.stack_wdata_o, .core_stall_o, .sp_load_o, .sp_value_o, .vector_load_o, .vector_addr_o,
		.restore_valid_o, .restored_pc_o, .restored_x_o, .restored_a_o, .restored_cc_o, .mask_flag_o,
		.core_stop_o, .osc_stop_o, .slow_clock_select_i, .cpu_clk_o, .cpu_tick_o, .port_a_pins_i,
		.port_a_irq_en_i, .port_b_pins_i, .port_b_irq_en_i, .port_c_low_pins_i, .port_c_irq_en_i,
		.group_a_polarity_bits_i, .group_b_polarity_bits_i, .periph_flag_set_i, .periph_clr_i,
		.periph_en_i, .periph_pending_o);

	mic_stack_mem mem (.clk_i(core_clk_i), .wr_i(stack_wr_o), .rd_i(stack_rd_o), .addr_i(stack_addr_o),
		.wdata_i(stack_wdata_o), .rdata_o(stack_rdata_i));

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge core_clk_i);
	endtask

	task automatic mask_pulse(input logic clr);
		clr_mask_i = clr;
		set_mask_i = ~clr;
		cyc(1);
		clr_mask_i = 1'b0;
		set_mask_i = 1'b0;
		cyc(1);
	endtask

	// Bounded wait for the vector load, then the stacked pointer and mask
	task automatic enter(input logic [15:0] vec, input logic use_end);
		int k;
		instr_end_i = use_end;
		cyc(1);
		instr_end_i = 1'b0;
		for (k = 0; k < 20 && vector_load_o !== 1'b1; k++)
			cyc(1);
		chk("vector", vector_addr_o, vec);
		chk("sp_entry", sp_value_o, SP_RESET - 16'h5);
		chk("entry_loads", 16'({sp_load_o, core_stall_o}), 16'h3);
		cyc(1);
		chk("mask_entry", 16'({core_stall_o, mask_flag_o}), 16'h1);
	endtask

	task automatic no_entry(input string what);
		int k;
		logic seen;
		seen = 1'b0;
		instr_end_i = 1'b1;
		cyc(1);
		instr_end_i = 1'b0;
		for (k = 0; k < 12; k++)
		begin
			seen = seen | vector_load_o;
			cyc(1);
		end
		chk(what, 16'(seen), 16'h0);
	endtask

	task automatic ret();
		int k;
		stack_ptr_i = SP_RESET - 16'h5;
		interrupt_return_instruction_exec_i = 1'b1;
		cyc(1);
		interrupt_return_instruction_exec_i = 1'b0;
		for (k = 0; k < 20 && restore_valid_o !== 1'b1; k++)
			cyc(1);
		chk("rest_pc", restored_pc_o, program_counter_i);
		chk("rest_xa", {restored_x_o, restored_a_o}, {index_reg_i, accum_i});
		chk("rest_cc", 16'(restored_cc_o), 16'(exp_cc));
		chk("sp_ret", sp_value_o, SP_RESET);
		cyc(1);
		chk("mask_ret", 16'(mask_flag_o), 16'(exp_cc[CC_MASK_BIT]));
		stack_ptr_i = SP_RESET;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic test_ext();
		mask_pulse(1'b1);
		port_a_pins_i = 8'hfc;
		cyc(4);
		port_a_pins_i = 8'hfe;
		cyc(4);
		no_entry("low_pin_blocks");
		mask_pulse(1'b0);
		group_a_polarity_bits_i = POL_FALL_LOW;
		cyc(4);
		no_entry("masked_level");
		mask_pulse(1'b1);
		enter(VEC_GRP_A, 1'b1);
		chk("push_pc", {mem.m[9'h17e], mem.m[9'h17f]}, 16'h1234);
		chk("push_xa", {mem.m[9'h17d], mem.m[9'h17c]}, 16'h5678);
		chk("push_cc", 16'(mem.m[9'h17b]), 16'h00a1);
		ret();
		enter(VEC_GRP_A, 1'b1);
		port_a_pins_i = 8'hff;
		port_c_low_pins_i = 6'h3e;
		ret();
		enter(VEC_GRP_B, 1'b1);
		port_c_low_pins_i = 6'h3f;
		ret();
		$display("test_ext done");
	endtask

	task automatic test_prio();
		mask_pulse(1'b0);
		periph_en_i = 3'h4;
		periph_flag_set_i = 3'h4;
		trap_exec_i = 1'b1;
		cyc(1);
		periph_flag_set_i = 3'h0;
		trap_exec_i = 1'b0;
		enter(VEC_TRAP, 1'b1);
		// Trap taken under mask stacks the mask bit set, so return keeps it set
		exp_cc = 8'ha9;
		ret();
		exp_cc = 8'ha1;
		mask_pulse(1'b1);
		enter(VEC_TIM_B, 1'b1);
		periph_clr_i = 3'h4;
		cyc(2);
		periph_clr_i = 3'h0;
		chk("tb_cleared", 16'(periph_pending_o), 16'h0);
		ret();
		$display("test_prio done");
	endtask

	task automatic test_periph();
		periph_en_i = 3'h0;
		periph_flag_set_i = 3'h1;
		cyc(1);
		periph_flag_set_i = 3'h0;
		cyc(1);
		chk("pend_latched", 16'(periph_pending_o), 16'h1);
		no_entry("not_enabled");
		periph_clr_i = 3'h1;
		cyc(1);
		periph_clr_i = 3'h0;
		cyc(1);
		chk("pend_lost", 16'(periph_pending_o), 16'h0);
		periph_en_i = 3'h1;
		no_entry("lost_stays_lost");
		$display("test_periph done");
	endtask

	task automatic test_lowpower();
		mask_pulse(1'b0);
		wfi_exec_i = 1'b1;
		cyc(1);
		wfi_exec_i = 1'b0;
		cyc(1);
		chk("wait_state", {core_stop_o, mask_flag_o}, 16'h2);
		periph_en_i = 3'h2;
		periph_flag_set_i = 3'h2;
		cyc(1);
		periph_flag_set_i = 3'h0;
		enter(VEC_TIM_A, 1'b0);
		periph_clr_i = 3'h2;
		cyc(1);
		periph_clr_i = 3'h0;
		ret();
		halt_exec_i = 1'b1;
		cyc(1);
		halt_exec_i = 1'b0;
		periph_flag_set_i = 3'h2;
		cyc(1);
		periph_flag_set_i = 3'h0;
		no_entry("timer_no_halt_exit");
		chk("halt_state", {core_stop_o, osc_stop_o}, 16'h3);
		port_a_pins_i = 8'hfe;
		enter(VEC_GRP_A, 1'b0);
		port_a_pins_i = 8'hff;
		periph_clr_i = 3'h2;
		cyc(1);
		periph_clr_i = 3'h0;
		ret();
		$display("test_lowpower done");
	endtask

	task automatic test_pol();
		group_b_polarity_bits_i = POL_FALL;
		port_c_low_pins_i = 6'h3e;
		cyc(4);
		enter(VEC_GRP_B, 1'b1);
		port_c_low_pins_i = 6'h3f;
		ret();
		no_entry("fall_ignores_rise");
		group_b_polarity_bits_i = POL_BOTH;
		port_c_low_pins_i = 6'h3e;
		cyc(4);
		enter(VEC_GRP_B, 1'b1);
		// The rise that follows is latched and taken after return
		port_c_low_pins_i = 6'h3f;
		ret();
		enter(VEC_GRP_B, 1'b1);
		ret();
		mask_pulse(1'b0);
		port_c_low_pins_i = 6'h3e;
		cyc(4);
		group_b_polarity_bits_i = POL_FALL;
		cyc(2);
		mask_pulse(1'b1);
		no_entry("pol_change_discard");
		port_c_low_pins_i = 6'h3f;
		cyc(4);
		group_b_polarity_bits_i = POL_FALL_LOW;
		cyc(2);
		$display("test_pol done");
	endtask

	task automatic period(input logic slow, input int exp);
		int k;
		int n;
		int h;
		logic p;
		slow_clock_select_i = slow;
		cyc(70);
		for (k = 0; k < 80 && cpu_tick_o !== 1'b1; k++)
			cyc(1);
		p = cpu_clk_o;
		cyc(1);
		n = 1;
		h = int'(cpu_clk_o === 1'b1 && p === 1'b0);
		while (n < 80 && cpu_tick_o !== 1'b1)
		begin
			p = cpu_clk_o;
			n++;
			cyc(1);
			h += int'(cpu_clk_o === 1'b1 && p === 1'b0);
		end
		chk("cpu_period", 16'(n), 16'(exp));
		// One full cpu clock period holds exactly one rising edge
		chk("cpu_rises", 16'(h), 16'h1);
	endtask

	task automatic complete_run();
		$display("tests %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		cyc(1);
		chk("rst_vec", vector_addr_o, VEC_RESET);
		cyc(2);
		reset_n_i = 1'b1;
		cyc(2);
		chk("rst_mask", 16'(mask_flag_o), 16'h1);
		test_ext();
		test_prio();
		test_periph();
		test_lowpower();
		test_pol();
		period(1'b0, 2);
		period(1'b1, 32);
		$display("test_clk done");
		complete_run();
	end

	// Whole run needs well under two thousand cycles
	initial
	begin
		#20000;
		num_errors++;
		complete_run();
	end
endmodule
